// file: mtg_trajectory.sv
// Trajectory generator with object registers, quick stop and velocity-loop limiter
// ==========================================================
// How it works
// - Profile velocity mode follows target velocity at once, no trigger needed.
// - Profile position parameters latch only on control-word bit 4 rising edge.
// - Profile position cruises at the latched profile velocity.
// - Move ends heading for the end velocity, normally zero.
// - End velocity is used only by the trapezoidal generator.
// - Profile acceleration drives acceleration; S-curve also decelerates with it.
// - Profile deceleration serves trapezoid and special velocity profiles only.
// - Quick stop ramps command velocity to zero by quick-stop deceleration.
// - Quick-stop deceleration is live, never buffered.
// - Zero quick-stop deceleration zeroes trajectory velocity at once; velocity-loop command still ramps at max deceleration.
// - Profile type accepts only 0, 3 and -1; other writes rejected.
// - Velocity-loop input rises in magnitude no faster than max acceleration.
// - Velocity-loop input falls in magnitude no faster than max deceleration.
// - Max motor speed clamps command symmetrically in both directions.
module mtg_trajectory (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic tick,
  input wire logic ppMode,
  input wire logic pvMode,
  input wire logic [15:0] controlWord,
  input wire logic quickStop,
  input wire logic moveNegative,
  input wire logic nearTarget,
  input wire logic objWrite,
  input wire logic objRead,
  input wire logic [15:0] objIndex,
  input wire logic [31:0] objWrData,
  output logic [31:0] objRdData,
  output logic objError,
  output logic [31:0] trajVelocity,
  output logic [31:0] vloopCommand
);

  typedef struct packed {
    logic [31:0] maxSpeed;
    logic [31:0] cruiseVel;
    logic [31:0] endVel;
    logic [31:0] accel;
    logic [31:0] decel;
    logic [31:0] qsDecel;
    logic [15:0] profType;
    logic [31:0] jerk;
    logic [31:0] vlAccel;
    logic [31:0] vlDecel;
    logic [31:0] targetVel;
    logic [31:0] actCruise;
    logic [31:0] actEnd;
    logic [31:0] actAccel;
    logic [31:0] actDecel;
    logic [15:0] actType;
    logic cwPrev;
    logic [31:0] trajVel;
    logic [31:0] vloopVel;
    logic [31:0] rdData;
    logic err;
  } mtg_state_t;

  mtg_state_t st_r;
  mtg_state_t st_nxt;

  // ==========================================================
  // Helpers
  function automatic logic [31:0] stepToward(input logic [31:0] cur, input logic [31:0] tgt,
                                             input logic [31:0] rate);
    logic signed [32:0] d;
    logic signed [32:0] r;
    d = $signed({tgt[31], tgt}) - $signed({cur[31], cur});
    r = $signed({1'b0, rate});
    if (d > 0) begin
      stepToward = (d <= r) ? tgt : 32'(cur + rate);
    end else if (d < 0) begin
      stepToward = (-d <= r) ? tgt : 32'(cur - rate);
    end else begin
      stepToward = tgt;
    end
  endfunction

  function automatic logic [31:0] clampSpeed(input logic [31:0] v, input logic [31:0] lim);
    logic signed [32:0] m;
    logic signed [32:0] s;
    m = $signed({1'b0, lim});
    s = $signed({v[31], v});
    if (s > m) begin
      clampSpeed = m[31:0];
    end else if (s < -m) begin
      clampSpeed = 32'(-m);
    end else begin
      clampSpeed = v;
    end
  endfunction

  function automatic logic validType(input logic [15:0] t);
    validType = (t == mtg_pkg::PT_TRAPEZOID) || (t == mtg_pkg::PT_SCURVE) || (t == mtg_pkg::PT_VELOCITY);
  endfunction

  // ==========================================================
  // Next state
  logic cwRise;
  logic [31:0] goalVel;
  logic [31:0] goalRate;
  logic [31:0] vlGoal;
  logic growing;

  assign cwRise = controlWord[mtg_pkg::CW_START_BIT] & ~st_r.cwPrev;

  always_comb begin
    st_nxt = st_r;
    st_nxt.cwPrev = controlWord[mtg_pkg::CW_START_BIT];
    st_nxt.err = 1'b0;
    goalVel = 32'h00000000;
    goalRate = st_r.actAccel;
    if (objWrite) begin
      unique case (objIndex)
        mtg_pkg::IDX_MAX_MOTOR_SPEED: st_nxt.maxSpeed = objWrData;
        mtg_pkg::IDX_CRUISE_VELOCITY: st_nxt.cruiseVel = objWrData;
        mtg_pkg::IDX_END_VELOCITY: st_nxt.endVel = objWrData;
        mtg_pkg::IDX_PROFILE_ACCEL: st_nxt.accel = objWrData;
        mtg_pkg::IDX_PROFILE_DECEL: st_nxt.decel = objWrData;
        mtg_pkg::IDX_QUICK_STOP_DECEL: st_nxt.qsDecel = objWrData;
        mtg_pkg::IDX_PROFILE_TYPE_SELECT: begin
          if (validType(objWrData[15:0]) && objWrData[31:16] == 16'h0000) begin
            st_nxt.profType = objWrData[15:0];
          end else begin
            st_nxt.err = 1'b1;
          end
        end
        mtg_pkg::IDX_JERK_LIMIT_ONE: st_nxt.jerk = objWrData;
        mtg_pkg::IDX_VLOOP_MAX_ACCEL: st_nxt.vlAccel = objWrData;
        mtg_pkg::IDX_VLOOP_MAX_DECEL: st_nxt.vlDecel = objWrData;
        mtg_pkg::IDX_TARGET_VELOCITY: st_nxt.targetVel = objWrData;
        default: st_nxt.err = 1'b1;
      endcase
    end
    if (objRead) begin
      unique case (objIndex)
        mtg_pkg::IDX_MAX_MOTOR_SPEED: st_nxt.rdData = st_r.maxSpeed;
        mtg_pkg::IDX_CRUISE_VELOCITY: st_nxt.rdData = st_r.cruiseVel;
        mtg_pkg::IDX_END_VELOCITY: st_nxt.rdData = st_r.endVel;
        mtg_pkg::IDX_PROFILE_ACCEL: st_nxt.rdData = st_r.accel;
        mtg_pkg::IDX_PROFILE_DECEL: st_nxt.rdData = st_r.decel;
        mtg_pkg::IDX_QUICK_STOP_DECEL: st_nxt.rdData = st_r.qsDecel;
        mtg_pkg::IDX_PROFILE_TYPE_SELECT: st_nxt.rdData = {{16{st_r.profType[15]}}, st_r.profType};
        mtg_pkg::IDX_JERK_LIMIT_ONE: st_nxt.rdData = st_r.jerk;
        mtg_pkg::IDX_VLOOP_MAX_ACCEL: st_nxt.rdData = st_r.vlAccel;
        mtg_pkg::IDX_VLOOP_MAX_DECEL: st_nxt.rdData = st_r.vlDecel;
        mtg_pkg::IDX_TARGET_VELOCITY: st_nxt.rdData = st_r.targetVel;
        default: begin
          st_nxt.rdData = 32'h00000000;
          st_nxt.err = 1'b1;
        end
      endcase
    end
    // Buffered move parameters
    if (ppMode && cwRise) begin
      st_nxt.actCruise = st_r.cruiseVel;
      st_nxt.actEnd = st_r.endVel;
      st_nxt.actAccel = st_r.accel;
      st_nxt.actDecel = st_r.decel;
      st_nxt.actType = st_r.profType;
    end
    // Generator goal
    if (pvMode) begin
      goalVel = st_r.targetVel;
      goalRate = st_r.accel;
    end else if (ppMode && nearTarget) begin
      goalVel = (st_r.actType == mtg_pkg::PT_TRAPEZOID) ? st_r.actEnd : 32'h00000000;
      goalRate = (st_r.actType == mtg_pkg::PT_SCURVE) ? st_r.actAccel : st_r.actDecel;
      goalVel = moveNegative ? 32'(-goalVel) : goalVel;
    end else if (ppMode) begin
      goalVel = moveNegative ? 32'(-st_r.actCruise) : st_r.actCruise;
      goalRate = st_r.actAccel;
    end
    goalVel = clampSpeed(goalVel, st_r.maxSpeed);
    if (quickStop) begin
      goalVel = 32'h00000000;
      goalRate = st_r.qsDecel;
    end
    if (quickStop && st_r.qsDecel == 32'h00000000) begin
      st_nxt.trajVel = 32'h00000000;
    end else if (!ppMode && !pvMode && !quickStop) begin
      st_nxt.trajVel = 32'h00000000;
    end else if (tick) begin
      st_nxt.trajVel = stepToward(st_r.trajVel, goalVel, goalRate);
    end
    // Velocity-loop input limiter
    vlGoal = clampSpeed(st_r.trajVel, st_r.maxSpeed);
    growing = ($signed(vlGoal) > $signed(st_r.vloopVel) && !st_r.vloopVel[31]) ||
              ($signed(vlGoal) < $signed(st_r.vloopVel) && (st_r.vloopVel[31] || st_r.vloopVel == 32'h0));
    if (tick) begin
      // Through zero: shed speed first, then build it
      if (!growing && (vlGoal[31] != st_r.vloopVel[31]) && vlGoal != 32'h0) begin
        st_nxt.vloopVel = stepToward(st_r.vloopVel, 32'h00000000, st_r.vlDecel);
      end else begin
        st_nxt.vloopVel = stepToward(st_r.vloopVel, vlGoal, growing ? st_r.vlAccel : st_r.vlDecel);
      end
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= '{maxSpeed: mtg_pkg::RST_MAX_MOTOR_SPEED, cruiseVel: mtg_pkg::RST_ZERO,
                endVel: mtg_pkg::RST_ZERO, accel: mtg_pkg::RST_ZERO, decel: mtg_pkg::RST_ZERO,
                qsDecel: mtg_pkg::RST_ZERO, profType: mtg_pkg::RST_PROFILE_TYPE,
                jerk: mtg_pkg::RST_ZERO, vlAccel: mtg_pkg::RST_VLOOP_LIMIT,
                vlDecel: mtg_pkg::RST_VLOOP_LIMIT, targetVel: mtg_pkg::RST_ZERO,
                actCruise: mtg_pkg::RST_ZERO, actEnd: mtg_pkg::RST_ZERO, actAccel: mtg_pkg::RST_ZERO,
                actDecel: mtg_pkg::RST_ZERO, actType: mtg_pkg::RST_PROFILE_TYPE, cwPrev: 1'b0,
                trajVel: mtg_pkg::RST_ZERO, vloopVel: mtg_pkg::RST_ZERO, rdData: mtg_pkg::RST_ZERO,
                err: 1'b0};
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign objRdData = st_r.rdData;
  assign objError = st_r.err;
  assign trajVelocity = st_r.trajVel;
  assign vloopCommand = st_r.vloopVel;

  // ==========================================================
  // Checks
  type_valid_a: assert property (@(posedge clock) disable iff (!rst_b)
    validType(st_r.profType)) else $error("profile type holds illegal code");

  type_reject_a: assert property (@(posedge clock) disable iff (!rst_b)
    ce && objWrite && objIndex == mtg_pkg::IDX_PROFILE_TYPE_SELECT && !validType(objWrData[15:0])
    |=> objError && $stable(st_r.profType)) else $error("bad profile type not rejected");

  latch_on_rise_a: assert property (@(posedge clock) disable iff (!rst_b)
    ce && ppMode && cwRise |=> st_r.actAccel == $past(st_r.accel) && st_r.actCruise == $past(st_r.cruiseVel))
    else $error("move parameters not taken on trigger");

  buffer_hold_a: assert property (@(posedge clock) disable iff (!rst_b)
    !(ce && ppMode && cwRise) |=> $stable(st_r.actAccel) && $stable(st_r.actType))
    else $error("buffered parameters changed without trigger");

  qs_instant_a: assert property (@(posedge clock) disable iff (!rst_b)
    ce && quickStop && st_r.qsDecel == 32'h0 |=> trajVelocity == 32'h0)
    else $error("zero quick-stop decel did not stop at once");

  qs_ramp_a: assert property (@(posedge clock) disable iff (!rst_b)
    ce && tick && quickStop && !st_r.trajVel[31] && !st_r.qsDecel[31] && st_r.qsDecel != 32'h0
    |=> !trajVelocity[31] && ($past(st_r.trajVel) <= $past(st_r.qsDecel) ? trajVelocity == 32'h0 :
        trajVelocity == 32'($past(st_r.trajVel) - $past(st_r.qsDecel))))
    else $error("quick-stop ramp step wrong");

  speed_clamp_a: assert property (@(posedge clock) disable iff (!rst_b)
    ce && tick && !st_r.maxSpeed[31] |=> $signed(vloopCommand) <= $signed({1'b0, $past(st_r.maxSpeed)}) ||
      $signed(vloopCommand) <= $signed($past(vloopCommand)))
    else $error("command exceeds max motor speed");

  vl_accel_a: assert property (@(posedge clock) disable iff (!rst_b)
    !$past(vloopCommand[31]) && $signed(vloopCommand) > $signed($past(vloopCommand))
    |-> 32'(vloopCommand - $past(vloopCommand)) <= $past(st_r.vlAccel))
    else $error("velocity-loop rise exceeds max accel");

  vl_decel_a: assert property (@(posedge clock) disable iff (!rst_b)
    !vloopCommand[31] && $signed(vloopCommand) < $signed($past(vloopCommand)) && !$past(vloopCommand[31])
    |-> 32'($past(vloopCommand) - vloopCommand) <= $past(st_r.vlDecel))
    else $error("velocity-loop fall exceeds max decel");

  tick_pace_a: assert property (@(posedge clock) disable iff (!rst_b)
    !(ce && tick) |=> $stable(vloopCommand)) else $error("limiter moved without tick");

  // ==========================================================
  // Direction, profile and enable checks
  vl_accel_neg_a: assert property (@(posedge clock) disable iff (!rst_b)
    $past(vloopCommand[31]) && $signed(vloopCommand) < $signed($past(vloopCommand))
    |-> 32'($past(vloopCommand) - vloopCommand) <= $past(st_r.vlAccel))
    else $error("velocity-loop reverse rise exceeds max accel");

  vl_decel_neg_a: assert property (@(posedge clock) disable iff (!rst_b)
    vloopCommand[31] && $past(vloopCommand[31]) && $signed(vloopCommand) > $signed($past(vloopCommand))
    |-> 32'(vloopCommand - $past(vloopCommand)) <= $past(st_r.vlDecel))
    else $error("velocity-loop reverse fall exceeds max decel");

  pv_follow_a: assert property (@(posedge clock) disable iff (!rst_b)
    ce && tick && pvMode && !quickStop && st_r.maxSpeed == 32'hFFFFFFFF && st_r.accel != 32'h0 &&
    st_r.trajVel != st_r.targetVel |=> trajVelocity != $past(st_r.trajVel))
    else $error("target velocity change not followed at once");

  cruise_cap_a: assert property (@(posedge clock) disable iff (!rst_b)
    ce && tick && ppMode && !pvMode && !quickStop && !nearTarget && !moveNegative && st_r.maxSpeed[31] &&
    !st_r.actCruise[31] && !st_r.trajVel[31] && st_r.trajVel <= st_r.actCruise
    |=> !trajVelocity[31] && trajVelocity <= $past(st_r.actCruise))
    else $error("move exceeds latched cruise velocity");

  s_curve_end_a: assert property (@(posedge clock) disable iff (!rst_b)
    ce && tick && ppMode && !pvMode && !quickStop && nearTarget && st_r.actType == mtg_pkg::PT_SCURVE &&
    !st_r.trajVel[31] && st_r.trajVel <= st_r.actAccel |=> trajVelocity == 32'h0)
    else $error("S-curve move did not end at zero");

  ce_freeze_a: assert property (@(posedge clock) disable iff (!rst_b)
    !ce |=> $stable(trajVelocity) && $stable(vloopCommand) && $stable(objRdData) && $stable(objError))
    else $error("state moved while clock enable low");

endmodule // mtg_trajectory

// file: mtg_pkg.sv
// Object indices, reset values and profile codes of the trajectory generator
package mtg_pkg;
  // ==========================================================
  // Object indices
  localparam logic [15:0] IDX_MAX_MOTOR_SPEED = 16'h6080;
  localparam logic [15:0] IDX_CRUISE_VELOCITY = 16'h6081;
  localparam logic [15:0] IDX_END_VELOCITY = 16'h6082;
  localparam logic [15:0] IDX_PROFILE_ACCEL = 16'h6083;
  localparam logic [15:0] IDX_PROFILE_DECEL = 16'h6084;
  localparam logic [15:0] IDX_QUICK_STOP_DECEL = 16'h6085;
  localparam logic [15:0] IDX_PROFILE_TYPE_SELECT = 16'h6086;
  localparam logic [15:0] IDX_JERK_LIMIT_ONE = 16'h60A4;
  localparam logic [15:0] IDX_VLOOP_MAX_ACCEL = 16'h60C5;
  localparam logic [15:0] IDX_VLOOP_MAX_DECEL = 16'h60C6;
  localparam logic [15:0] IDX_TARGET_VELOCITY = 16'h60FF;
  // ==========================================================
  // Profile type codes
  localparam logic [15:0] PT_TRAPEZOID = 16'h0000;
  localparam logic [15:0] PT_SCURVE = 16'h0003;
  localparam logic [15:0] PT_VELOCITY = 16'hFFFF;
  // ==========================================================
  // Control word trigger position
  localparam int CW_START_BIT = 4;
  // ==========================================================
  // Reset values
  localparam logic [31:0] RST_MAX_MOTOR_SPEED = 32'hFFFFFFFF;
  localparam logic [31:0] RST_VLOOP_LIMIT = 32'hFFFFFFFF;
  localparam logic [31:0] RST_ZERO = 32'h00000000;
  localparam logic [15:0] RST_PROFILE_TYPE = 16'h0000;
endpackage

// file: mtg_master_model.sv
// Network master model driving the object port and the control word
module mtg_master_model (
  input wire logic clock,
  output logic objWrite,
  output logic objRead,
  output logic [15:0] objIndex,
  output logic [31:0] objWrData,
  output logic [15:0] controlWord,
  input wire logic [31:0] objRdData,
  input wire logic objError
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    objWrite = 1'b0;
    objRead = 1'b0;
    objIndex = 16'h0000;
    objWrData = 32'h00000000;
    controlWord = 16'h0000;
  end

  // ==========================================================
  // Object access: one strobe cycle, answer one cycle later
  task automatic xfer(input logic wr, input logic [15:0] idx, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    @(negedge clock);
    objWrite = wr;
    objRead = ~wr;
    objIndex = idx;
    objWrData = d;
    @(negedge clock);
    // Error flag stands for one cycle only
    rd = objRdData;
    err = objError;
    objWrite = 1'b0;
    objRead = 1'b0;
    // Released bus shows junk, not the last value
    objIndex = ~idx;
    objWrData = ~d;
  endtask

  // ==========================================================
  // Move start: start bit low, high, low again before next use
  task automatic start_move();
    @(negedge clock);
    controlWord[mtg_pkg::CW_START_BIT] = 1'b1;
    @(negedge clock);
    controlWord[mtg_pkg::CW_START_BIT] = 1'b0;
    @(negedge clock);
  endtask
endmodule // mtg_master_model

// file: motion_trajectory_generator_tb_top.sv
// Self-checking testbench of the trajectory generator
module motion_trajectory_generator_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic clock = 1'b0;
  logic rst_b, ce, tick, ppMode, pvMode, quickStop, moveNegative, nearTarget;
  logic objWrite, objRead, objError;
  logic [15:0] objIndex, controlWord;
  logic [31:0] objWrData, objRdData, trajVelocity, vloopCommand, rd;
  logic err;
  int error_cnt = 0;
  int checks_done = 0;
  logic [15:0] idxTab [11] = '{16'h6080, 16'h6081, 16'h6082, 16'h6083, 16'h6084, 16'h6085,
                               16'h6086, 16'h60A4, 16'h60C5, 16'h60C6, 16'h60FF};
  logic [31:0] typeCode [3] = '{32'h0000FFFF, 32'h00000003, 32'h00000000};
  logic [31:0] typeRead [3] = '{32'hFFFFFFFF, 32'h00000003, 32'h00000000};

  always #12.5 clock = ~clock;

  mtg_trajectory i_dut (.clock(clock), .rst_b(rst_b), .ce(ce), .tick(tick), .ppMode(ppMode),
    .pvMode(pvMode), .controlWord(controlWord), .quickStop(quickStop), .moveNegative(moveNegative),
    .nearTarget(nearTarget), .objWrite(objWrite), .objRead(objRead), .objIndex(objIndex),
    .objWrData(objWrData), .objRdData(objRdData), .objError(objError), .trajVelocity(trajVelocity),
    .vloopCommand(vloopCommand));

  mtg_master_model i_master (.clock(clock), .objWrite(objWrite), .objRead(objRead),
    .objIndex(objIndex), .objWrData(objWrData), .controlWord(controlWord),
    .objRdData(objRdData), .objError(objError));

  // ==========================================================
  // Helpers
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %08h expected %08h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [15:0] idx, input logic [31:0] d);
    i_master.xfer(1'b1, idx, d, rd, err);
  endtask

  task automatic rdchk(input logic [15:0] idx, input logic [31:0] exp);
    i_master.xfer(1'b0, idx, 32'h00000000, rd, err);
    cmp(rd, exp);
  endtask

  task automatic tk(input int n);
    repeat (n) begin
      @(negedge clock);
      tick = 1'b1;
      @(negedge clock);
      tick = 1'b0;
    end
  endtask

  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    #50us;
    error_cnt++;
    wrap_up();
  end

  // ==========================================================
  // Main sequence
  initial begin
    rst_b = 1'b0;
    ce = 1'b1;
    tick = 1'b0;
    ppMode = 1'b0;
    pvMode = 1'b0;
    quickStop = 1'b0;
    moveNegative = 1'b0;
    nearTarget = 1'b0;
    repeat (3) @(negedge clock);
    rst_b = 1'b1;
    for (int i = 0; i < 11; i++) begin
      rdchk(idxTab[i], (i == 0 || i == 8 || i == 9) ? 32'hFFFFFFFF : 32'h00000000);
    end
    rdchk(16'h1234, 32'h00000000);
    cmp({31'h00000000, err}, 32'h00000001);
    for (int i = 0; i < 3; i++) begin
      wr(16'h6086, typeCode[i]);
      cmp({31'h00000000, err}, 32'h00000000);
      rdchk(16'h6086, typeRead[i]);
    end
    wr(16'h6086, 32'h00000005);
    cmp({31'h00000000, err}, 32'h00000001);
    rdchk(16'h6086, 32'h00000000);
    wr(16'h60A4, 32'h0000A5A5);
    rdchk(16'h60A4, 32'h0000A5A5);
    // Velocity mode with loop limits
    wr(16'h60C5, 32'h00000003);
    wr(16'h60C6, 32'h00000005);
    wr(16'h6083, 32'h0000000A);
    wr(16'h60FF, 32'h00000019);
    pvMode = 1'b1;
    tk(1);
    cmp(trajVelocity, 32'h0000000A);
    tk(4);
    cmp(trajVelocity, 32'h00000019);
    cmp(vloopCommand, 32'h0000000C);
    wr(16'h60FF, 32'h00000000);
    tk(4);
    cmp(trajVelocity, 32'h00000000);
    cmp(vloopCommand, 32'h00000005);
    wr(16'h6080, 32'h00000016);
    wr(16'h60FF, 32'hFFFFFF9C);
    tk(3);
    cmp(trajVelocity, 32'hFFFFFFEA);
    cmp(vloopCommand, 32'hFFFFFFFA);
    wr(16'h6080, 32'hFFFFFFFF);
    wr(16'h6083, 32'h00000064);
    wr(16'h60FF, 32'h00000028);
    wr(16'h6085, 32'h0000000F);
    tk(1);
    cmp(trajVelocity, 32'h00000028);
    // Quick stop
    quickStop = 1'b1;
    tk(1);
    cmp(trajVelocity, 32'h00000019);
    cmp(vloopCommand, 32'hFFFFFFFC);
    wr(16'h6085, 32'h00000014);
    tk(1);
    cmp(trajVelocity, 32'h00000005);
    tk(1);
    cmp(trajVelocity, 32'h00000000);
    quickStop = 1'b0;
    tk(1);
    cmp(trajVelocity, 32'h00000028);
    wr(16'h6085, 32'h00000000);
    quickStop = 1'b1;
    repeat (2) @(negedge clock);
    cmp(trajVelocity, 32'h00000000);
    quickStop = 1'b0;
    pvMode = 1'b0;
    // Profile position
    wr(16'h6081, 32'h0000001E);
    wr(16'h6083, 32'h00000008);
    wr(16'h6084, 32'h00000006);
    wr(16'h6082, 32'h00000004);
    ppMode = 1'b1;
    tk(1);
    cmp(trajVelocity, 32'h00000000);
    i_master.start_move();
    tk(4);
    cmp(trajVelocity, 32'h0000001E);
    nearTarget = 1'b1;
    tk(5);
    cmp(trajVelocity, 32'h00000004);
    nearTarget = 1'b0;
    wr(16'h6081, 32'h00000032);
    tk(1);
    cmp(trajVelocity, 32'h0000000C);
    wr(16'h6086, 32'h00000003);
    i_master.start_move();
    nearTarget = 1'b1;
    tk(1);
    cmp(trajVelocity, 32'h00000004);
    tk(1);
    cmp(trajVelocity, 32'h00000000);
    // Negative move, then clock-enable freeze
    nearTarget = 1'b0;
    moveNegative = 1'b1;
    tk(1);
    cmp(trajVelocity, 32'hFFFFFFF8);
    ce = 1'b0;
    tk(2);
    cmp(trajVelocity, 32'hFFFFFFF8);
    ce = 1'b1;
    tk(1);
    cmp(trajVelocity, 32'hFFFFFFF0);
    wrap_up();
  end
endmodule // motion_trajectory_generator_tb_top
